// ### rtl/ieeesr_map.svh
/*
 * Bit positions, used-bit masks and reset values of the status reporting
 * block. Definitions only; included by the package and the design file.
 */
`ifndef IEEESR_MAP_SVH
`define IEEESR_MAP_SVH

`define SR_W 8
// Status byte bits
`define SB_NEW_READ 0
`define SB_ALARM 3
`define SB_ERROR 4
`define SB_EVSUM 5
`define SB_RQS 6
`define SB_RAMP 7
`define SB_USED_MASK 8'hB9
// Standard event bits
`define EV_OPC 0
`define EV_QYE 2
`define EV_DDE 3
`define EV_EXE 4
`define EV_CME 5
`define EV_PON 7
`define EV_USED_MASK 8'hBD
// Reset values
`define SR_ZERO 8'h00
`define EV_PON_RESET 8'h80

`endif

// ### rtl/ieeesr_pkg.sv
/*
 * Types shared by the status reporting block.
 * Assumes the constant header is on the include path.
 */
`include "ieeesr_map.svh"
package ieeesr_pkg;
    // Common command performed on the registers, one cycle strobe
    typedef enum logic [2:0] {
        IEEESR_CMD_NONE,
        IEEESR_CMD_SRE_WR,
        IEEESR_CMD_ESE_WR,
        IEEESR_CMD_STB_RD,
        IEEESR_CMD_SRE_RD,
        IEEESR_CMD_ESR_RD,
        IEEESR_CMD_ESE_RD,
        IEEESR_CMD_SPOLL
    } ieeesr_cmd_t;
endpackage

// ### rtl/ieeesr_status.sv
/*
 * Status byte, service request enable, standard event register and its
 * enable, with the service request line. Assumes a command parser that
 * issues one decoded common command per strobe and a bus handshake that
 * carries the returned byte; the SRQ wire is open collector outside.
 */
`timescale 1ns/10ps
`include "ieeesr_map.svh"
module ieeesr_status
    import ieeesr_pkg::*;
(
    input wire logic clk_in, // 10 MHz clock
    input wire logic rstn_in, // Synchronous reset, active low
    input wire ieeesr_cmd_t cmd_in, // Decoded command, one cycle
    input wire logic [7:0] cmd_data_in, // Value for *SRE / *ESE
    input wire logic ramp_done_in, // Ramp completed pulse
    input wire logic inst_error_in, // Non-bus instrument error pulse
    input wire logic alarm_in, // Alarm condition level
    input wire logic new_reading_in, // New reading pulse
    input wire logic cmd_error_in, // Command parse error pulse
    input wire logic exec_error_in, // Execution error pulse
    input wire logic dev_error_in, // Device dependent error pulse
    input wire logic query_error_in, // Output queue overflow pulse
    input wire logic ops_done_in, // Pending operations finished pulse
    output logic [7:0] rd_data_out, // Byte returned by the last read
    output logic rd_valid_out, // Read answer strobe
    output logic srq_out, // SRQ output value, always low
    output logic srq_oe_out // SRQ drive enable, high pulls low
);
    logic [7:0] stb_q, stb_d;
    logic [7:0] sre_q, sre_d;
    logic [7:0] esr_q, esr_d;
    logic [7:0] ese_q, ese_d;
    logic opc_arm_q, opc_arm_d;
    logic [7:0] rd_data_d;
    logic rd_valid_d;
    logic srq_oe_d;
    logic [7:0] ev_set;
    logic [7:0] sb_set;
    logic [7:0] stb_view;
    logic ev_summary;
    logic [7:0] sb_reported;

    // Only events the controller enabled reach the summary bit
    assign ev_summary = |(esr_q & ese_q);
    assign stb_view = (stb_q | ({7'h00, ev_summary} << `SB_EVSUM)
        | ({7'h00, alarm_in} << `SB_ALARM)) & `SB_USED_MASK;
    // Bit 6 of the mask is the master enable, not a report
    assign sb_reported = stb_view & sre_q & `SB_USED_MASK;

    always_comb begin
        ev_set = `SR_ZERO;
        ev_set[`EV_CME] = cmd_error_in;
        ev_set[`EV_EXE] = exec_error_in;
        ev_set[`EV_DDE] = dev_error_in;
        ev_set[`EV_QYE] = query_error_in;
        ev_set[`EV_OPC] = ops_done_in & opc_arm_q;
        sb_set = `SR_ZERO;
        sb_set[`SB_RAMP] = ramp_done_in;
        sb_set[`SB_ERROR] = inst_error_in;
        sb_set[`SB_NEW_READ] = new_reading_in;
    end

    always_comb begin
        stb_d = stb_q;
        sre_d = sre_q;
        esr_d = esr_q;
        ese_d = ese_q;
        opc_arm_d = opc_arm_q;
        rd_data_d = rd_data_out;
        rd_valid_d = 1'b0;
        if (ops_done_in) begin
            opc_arm_d = 1'b0;
        end
        case (cmd_in)
            IEEESR_CMD_NONE: begin
            end
            IEEESR_CMD_SRE_WR: begin
                sre_d = cmd_data_in;
            end
            IEEESR_CMD_ESE_WR: begin
                ese_d = cmd_data_in & `EV_USED_MASK;
            end
            IEEESR_CMD_STB_RD: begin
                rd_data_d = stb_view | ({7'h00, srq_oe_out} << `SB_RQS);
                rd_valid_d = 1'b1;
            end
            IEEESR_CMD_SRE_RD: begin
                rd_data_d = sre_q;
                rd_valid_d = 1'b1;
            end
            IEEESR_CMD_ESR_RD: begin
                rd_data_d = esr_q;
                rd_valid_d = 1'b1;
                esr_d = `SR_ZERO;
            end
            IEEESR_CMD_ESE_RD: begin
                rd_data_d = ese_q;
                rd_valid_d = 1'b1;
            end
            IEEESR_CMD_SPOLL: begin
                // Returned whether or not requests are enabled
                rd_data_d = stb_view | ({7'h00, srq_oe_out} << `SB_RQS);
                rd_valid_d = 1'b1;
                stb_d = `SR_ZERO;
            end
            default: begin
            end
        endcase
        // A new event in the clearing cycle is kept
        stb_d = (stb_d | sb_set) & `SB_USED_MASK & ~(8'h01 << `SB_EVSUM)
            & ~(8'h01 << `SB_ALARM);
        esr_d = (esr_d | ev_set) & `EV_USED_MASK;
        // Built from next values so a mask write acts on the same edge
        srq_oe_d = sre_d[`SB_RQS] & (|(((stb_d
            | ({7'h00, |(esr_d & ese_d)} << `SB_EVSUM)
            | ({7'h00, alarm_in} << `SB_ALARM)) & sre_d & `SB_USED_MASK)));
    end

    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            stb_q <= `SR_ZERO;
            sre_q <= `SR_ZERO;
            esr_q <= `EV_PON_RESET;
            ese_q <= `SR_ZERO;
            opc_arm_q <= 1'b1;
            rd_data_out <= `SR_ZERO;
            rd_valid_out <= 1'b0;
            srq_oe_out <= 1'b0;
            srq_out <= 1'b0;
        end else begin
            stb_q <= stb_d;
            sre_q <= sre_d;
            esr_q <= esr_d;
            ese_q <= ese_d;
            opc_arm_q <= opc_arm_d;
            rd_data_out <= rd_data_d;
            rd_valid_out <= rd_valid_d;
            srq_oe_out <= srq_oe_d;
            srq_out <= 1'b0;
        end
    end

    a_srq_needs_enable: assert property (@(posedge clk_in) disable iff
        (!rstn_in) srq_oe_out |-> $past(sre_d[`SB_RQS]))
        else $error("SRQ driven while request enable bit clear");
    a_srq_follows_report: assert property (@(posedge clk_in) disable iff
        (!rstn_in) (sre_q[`SB_RQS] && (|sb_reported) && cmd_in ==
        IEEESR_CMD_NONE && sre_q == $past(sre_q)) |=> srq_oe_out)
        else $error("Enabled report did not raise SRQ");
    a_poll_clears: assert property (@(posedge clk_in) disable iff
        (!rstn_in) (cmd_in == IEEESR_CMD_SPOLL && sb_set == 8'h00)
        |=> stb_q == 8'h00 ##0 rd_valid_out)
        else $error("Serial poll did not clear status byte");
    a_stb_keeps: assert property (@(posedge clk_in) disable iff
        (!rstn_in) cmd_in == IEEESR_CMD_STB_RD |=> (stb_q & $past(stb_q))
        == $past(stb_q))
        else $error("Status byte query cleared bits");
    a_esr_clears: assert property (@(posedge clk_in) disable iff
        (!rstn_in) (cmd_in == IEEESR_CMD_ESR_RD && ev_set == 8'h00)
        |=> esr_q == 8'h00 && rd_data_out == $past(esr_q))
        else $error("Event register read did not clear");
    a_ese_readback: assert property (@(posedge clk_in) disable iff
        (!rstn_in) cmd_in == IEEESR_CMD_ESE_RD |=> rd_data_out ==
        $past(ese_q))
        else $error("Event enable query returned wrong value");
    a_unused_zero: assert property (@(posedge clk_in) disable iff
        (!rstn_in) (esr_q & ~`EV_USED_MASK) == 8'h00 &&
        (stb_view & ~`SB_USED_MASK) == 8'h00)
        else $error("Unused bit reads as one");
    a_event_sets: assert property (@(posedge clk_in) disable iff
        (!rstn_in) cmd_error_in |=> esr_q[`EV_CME])
        else $error("Command error not recorded");
    a_ramp_sets: assert property (@(posedge clk_in) disable iff
        (!rstn_in) ramp_done_in |=> stb_q[`SB_RAMP])
        else $error("Ramp done not recorded");

    // Enable masks and their readback

    a_sre_write: assert property (
        @(posedge clk_in) disable iff (!rstn_in)
        cmd_in == IEEESR_CMD_SRE_WR |=> sre_q == $past(cmd_data_in))
        else $error("Request enable write not stored");

    a_sre_readback: assert property (
        @(posedge clk_in) disable iff (!rstn_in)
        cmd_in == IEEESR_CMD_SRE_RD |=> rd_data_out == $past(sre_q))
        else $error("Request enable readback wrong");

    a_ese_write: assert property (
        @(posedge clk_in) disable iff (!rstn_in)
        cmd_in == IEEESR_CMD_ESE_WR |=> ese_q == ($past(cmd_data_in) & `EV_USED_MASK))
        else $error("Event enable write not stored");

    a_ese_unused: assert property (
        @(posedge clk_in) disable iff (!rstn_in)
        (ese_q & ~`EV_USED_MASK) == 8'h00)
        else $error("Event enable holds an unused bit");

    a_events_masked: assert property (
        @(posedge clk_in) disable iff (!rstn_in)
        ese_q == 8'h00 |-> !stb_view[`SB_EVSUM])
        else $error("Summary set with every event masked");

    // Service request line

    a_srq_disabled: assert property (
        @(posedge clk_in) disable iff (!rstn_in)
        (!sre_q[`SB_RQS] && cmd_in != IEEESR_CMD_SRE_WR) |=> !srq_oe_out)
        else $error("SRQ driven with requests disabled");

    a_srq_open_drain: assert property (
        @(posedge clk_in) disable iff (!rstn_in)
        !srq_out)
        else $error("SRQ value is not low");

    a_srq_drops: assert property (
        @(posedge clk_in) disable iff (!rstn_in)
        (cmd_in == IEEESR_CMD_SPOLL && sb_set == 8'h00 && ev_set == 8'h00
        && !alarm_in && !ev_summary) |=> !srq_oe_out)
        else $error("SRQ stays after poll with nothing to report");

    a_poll_rqs_bit: assert property (
        @(posedge clk_in) disable iff (!rstn_in)
        cmd_in == IEEESR_CMD_SPOLL |=> rd_data_out[`SB_RQS] == $past(srq_oe_out))
        else $error("Poll answer request bit wrong");

    // Answers to reads

    a_poll_answers: assert property (
        @(posedge clk_in) disable iff (!rstn_in)
        cmd_in == IEEESR_CMD_SPOLL |=> rd_valid_out
        && (rd_data_out & `SB_USED_MASK) == $past(stb_view))
        else $error("Poll answer wrong");

    a_stb_answers: assert property (
        @(posedge clk_in) disable iff (!rstn_in)
        cmd_in == IEEESR_CMD_STB_RD |=> rd_valid_out
        && (rd_data_out & `SB_USED_MASK) == $past(stb_view))
        else $error("Status query answer wrong");

    a_read_strobe: assert property (
        @(posedge clk_in) disable iff (!rstn_in)
        (cmd_in != IEEESR_CMD_NONE && cmd_in != IEEESR_CMD_SRE_WR
        && cmd_in != IEEESR_CMD_ESE_WR) |=> rd_valid_out)
        else $error("Read gave no answer strobe");

    a_write_silent: assert property (
        @(posedge clk_in) disable iff (!rstn_in)
        (cmd_in == IEEESR_CMD_NONE || cmd_in == IEEESR_CMD_SRE_WR
        || cmd_in == IEEESR_CMD_ESE_WR) |=> !rd_valid_out)
        else $error("Answer strobe without a read");

    // Status byte reports

    a_summary_on: assert property (
        @(posedge clk_in) disable iff (!rstn_in)
        (|(esr_q & ese_q)) |-> stb_view[`SB_EVSUM])
        else $error("Event summary bit missing");

    a_summary_off: assert property (
        @(posedge clk_in) disable iff (!rstn_in)
        !(|(esr_q & ese_q)) |-> !stb_view[`SB_EVSUM])
        else $error("Event summary bit set with no event");

    a_error_sets: assert property (
        @(posedge clk_in) disable iff (!rstn_in)
        inst_error_in |=> stb_q[`SB_ERROR])
        else $error("Instrument error not recorded");

    a_alarm_live: assert property (
        @(posedge clk_in) disable iff (!rstn_in)
        stb_view[`SB_ALARM] == alarm_in)
        else $error("Alarm bit does not follow alarm level");

    a_alarm_not_kept: assert property (
        @(posedge clk_in) disable iff (!rstn_in)
        !stb_q[`SB_ALARM])
        else $error("Alarm bit latched in status byte");

    a_reading_sets: assert property (
        @(posedge clk_in) disable iff (!rstn_in)
        new_reading_in |=> stb_q[`SB_NEW_READ])
        else $error("New reading not recorded");

    a_stb_unused: assert property (
        @(posedge clk_in) disable iff (!rstn_in)
        (stb_q & ~`SB_USED_MASK) == 8'h00)
        else $error("Status byte holds an unused bit");

    // Standard event register

    a_power_on: assert property (
        @(posedge clk_in) disable iff (!rstn_in)
        $rose(rstn_in) |-> esr_q[`EV_PON])
        else $error("Power-on bit missing after reset");

    a_exec_sets: assert property (
        @(posedge clk_in) disable iff (!rstn_in)
        exec_error_in |=> esr_q[`EV_EXE])
        else $error("Execution error not recorded");

    a_dev_sets: assert property (
        @(posedge clk_in) disable iff (!rstn_in)
        dev_error_in |=> esr_q[`EV_DDE])
        else $error("Device error not recorded");

    a_query_sets: assert property (
        @(posedge clk_in) disable iff (!rstn_in)
        query_error_in |=> esr_q[`EV_QYE])
        else $error("Query error not recorded");

    // Completion is only taken once per arming
    a_opc_sets: assert property (
        @(posedge clk_in) disable iff (!rstn_in)
        (ops_done_in && opc_arm_q) |=> esr_q[`EV_OPC])
        else $error("Operation complete not recorded");

    a_opc_once: assert property (
        @(posedge clk_in) disable iff (!rstn_in)
        ops_done_in |=> !opc_arm_q)
        else $error("Completion flag still armed");

endmodule

// ### test/ieee488_status_reporting_test.sv
/* Self-checking bench for the status reporting block.
   Assumes the controller model drives commands at the falling edge. */
`timescale 1ns/10ps
module ieee488_status_reporting_test import ieeesr_pkg::*; ;
    logic clk = 1'b0, rstn = 1'b0, alarm = 1'b0;
    logic [7:0] ev = 8'h00, rd_data, cmd_data;
    logic rd_valid, srq, srq_oe, srq_line;
    ieeesr_cmd_t cmd;
    int fails = 0, checks_done = 0;
    always #50 clk = ~clk;
    ieeesr_ctrl_model ctrl (.clk_in(clk), .srq_in(srq), .srq_oe_in(srq_oe),
        .cmd_out(cmd), .data_out(cmd_data), .srq_line_out(srq_line));
    ieeesr_status dut (.clk_in(clk), .rstn_in(rstn), .cmd_in(cmd),
        .cmd_data_in(cmd_data), .ramp_done_in(ev[0]),
        .inst_error_in(ev[1]), .alarm_in(alarm), .new_reading_in(ev[2]),
        .cmd_error_in(ev[3]), .exec_error_in(ev[4]), .dev_error_in(ev[5]),
        .query_error_in(ev[6]), .ops_done_in(ev[7]), .rd_data_out(rd_data),
        .rd_valid_out(rd_valid), .srq_out(srq), .srq_oe_out(srq_oe));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic rd(input ieeesr_cmd_t c, input logic [7:0] exp);
        ctrl.send(c, 8'h00);
        chk({7'h00, rd_valid}, 8'h01);
        chk(rd_data, exp);
    endtask
    task automatic pulse(input int n);
        @(negedge clk);
        ev[n] = 1'b1;
        @(negedge clk);
        ev[n] = 1'b0;
    endtask
    task automatic t_reset();
        rd(IEEESR_CMD_STB_RD, 8'h00);
        rd(IEEESR_CMD_ESE_RD, 8'h00);
        rd(IEEESR_CMD_ESR_RD, 8'h80);
        rd(IEEESR_CMD_ESR_RD, 8'h00);
    endtask
    task automatic t_status();
        alarm = 1'b1;
        pulse(0);
        pulse(1);
        pulse(2);
        rd(IEEESR_CMD_STB_RD, 8'h99);
        rd(IEEESR_CMD_STB_RD, 8'h99);
        rd(IEEESR_CMD_SPOLL, 8'h99);
        chk({7'h00, srq_oe}, 8'h00);
        rd(IEEESR_CMD_STB_RD, 8'h08);
        alarm = 1'b0;
    endtask
    task automatic t_srq();
        ctrl.send(IEEESR_CMD_SRE_WR, 8'h41);
        pulse(2);
        chk({7'h00, srq_line}, 8'h00);
        ctrl.send(IEEESR_CMD_SPOLL, 8'h00);
        chk(rd_data & 8'hB9, 8'h01);
        chk({7'h00, srq_line}, 8'h01);
        ctrl.send(IEEESR_CMD_SRE_WR, 8'h01);
        pulse(2);
        chk({7'h00, srq_oe}, 8'h00);
        ctrl.send(IEEESR_CMD_SRE_WR, 8'h40);
        chk({7'h00, srq_oe}, 8'h00);
        rd(IEEESR_CMD_SRE_RD, 8'h40);
        ctrl.send(IEEESR_CMD_SPOLL, 8'h00);
    endtask
    task automatic t_events();
        ctrl.send(IEEESR_CMD_ESE_WR, 8'hFF);
        rd(IEEESR_CMD_ESE_RD, 8'hBD);
        ctrl.send(IEEESR_CMD_SRE_WR, 8'h60);
        for (int n = 3; n < 8; n++) begin
            pulse(n);
        end
        chk({7'h00, srq_oe}, 8'h01);
        rd(IEEESR_CMD_STB_RD, 8'h60);
        rd(IEEESR_CMD_ESR_RD, 8'h3D);
        chk({7'h00, srq_oe}, 8'h00);
        ctrl.send(IEEESR_CMD_ESE_WR, 8'h00);
        pulse(3);
        chk({7'h00, srq_oe}, 8'h00);
        rd(IEEESR_CMD_STB_RD, 8'h00);
    endtask
    task automatic finish_test();
        $display("Checks %0d, errors %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // Whole sequence takes about 75 cycles
    initial begin
        #(100 * 1000);
        fails++;
        finish_test();
    end
    initial begin
        repeat (10) @(negedge clk);
        rstn = 1'b1;
        t_reset();
        t_status();
        t_srq();
        t_events();
        finish_test();
    end
endmodule

// ### test/ieeesr_ctrl_model.sv
/* Bus controller model: issues decoded common commands and resolves SRQ.
   Assumes the device samples commands on the rising clock edge. */
`timescale 1ns/10ps
module ieeesr_ctrl_model
    import ieeesr_pkg::*;
(
    input wire logic clk_in, // Shared clock
    input wire logic srq_in, // Device SRQ value
    input wire logic srq_oe_in, // Device SRQ drive enable
    output ieeesr_cmd_t cmd_out, // Command to device
    output logic [7:0] data_out, // Command value
    output logic srq_line_out // Resolved SRQ wire, low requests
);
    // Pull-up holds the wire high when nobody drives it
    assign srq_line_out = srq_oe_in ? srq_in : 1'b1;
    initial begin
        cmd_out = IEEESR_CMD_NONE;
        data_out = 8'h00;
    end
    task automatic send(input ieeesr_cmd_t c, input logic [7:0] d);
        @(negedge clk_in);
        cmd_out = c;
        data_out = d;
        @(negedge clk_in);
        cmd_out = IEEESR_CMD_NONE;
        data_out = ~d; // Stale value is not held
    endtask
endmodule
